// [hdl/fof_pkg.sv]
package fof_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned WORD_W      = 8;
  localparam int unsigned CMP_N       = 256;
  localparam int unsigned BUS_AW      = 5;
  localparam int unsigned BUS_DW      = 32;
  localparam int unsigned IRQ_W       = 2;
  // Nominal conversion rate; the fabric clock sets the real one
  localparam int unsigned SAMPLE_RATE_MSPS = 300;

  // ==========================================================
  // Register byte offsets
  localparam logic [BUS_AW-1:0] OFS_CTRL     = 5'h00;
  localparam logic [BUS_AW-1:0] OFS_STATUS   = 5'h04;
  localparam logic [BUS_AW-1:0] OFS_INT_STAT = 5'h08;
  localparam logic [BUS_AW-1:0] OFS_INT_MASK = 5'h0C;
  localparam logic [BUS_AW-1:0] OFS_COUNT    = 5'h10;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_MSB_INV   = 0;
  localparam int unsigned CTRL_LOW_INV   = 1;
  localparam int unsigned CTRL_VALID_POL = 2;
  localparam int unsigned CTRL_ENABLE    = 3;
  localparam int unsigned STAT_OVER      = 8;
  localparam int unsigned INT_OVER       = 0;
  localparam int unsigned INT_BUBBLE     = 1;

  // ==========================================================
  // Reset values
  localparam logic        CTRL_ENABLE_RST = 1'h1;
  localparam logic [IRQ_W-1:0] INT_MASK_RST = 2'h0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic msb_invert_ctl;
    logic lower_bits_invert_ctl;
    logic valid_polarity_ctl;
    logic enable;
  } fof_ctrl_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              over;
    logic              bubble;
  } fof_sample_t;

  typedef struct packed {
    logic [BUS_AW-1:0] address;
    logic              read;
    logic              write;
    logic [BUS_DW-1:0] writedata;
    logic [3:0]        byteenable;
  } fof_avm_req_t;

endpackage : fof_pkg

// [hdl/fof_therm_dec.sv]
`timescale 1ns/10ps
module fof_therm_dec
  import fof_pkg::*;
#(
  parameter int unsigned N_CMP = CMP_N,
  parameter int unsigned W     = WORD_W
) (
  input  wire logic [N_CMP-1:0] therm,
  output fof_sample_t           dec
);

  // ==========================================================
  // Checks
  if (N_CMP != (1 << W)) begin : g_bad_size
    $error("comparator count must equal two to the word width");
  end

  // ==========================================================
  // Decode
  // Edge needs two adjacent ones: a lone sparkle above the true edge is
  // ignored, so a bubble costs at most two codes; a sparkle on the top comparator alone still sets over
  always_comb begin
    dec = '0;
    if (therm[0]) begin
      dec.word = W'(1);
    end
    for (int i = 1; i < N_CMP - 1; i++) begin
      if (therm[i] && therm[i-1]) begin
        dec.word = W'(i + 1);
      end
      if (therm[i] && !therm[i-1]) begin
        dec.bubble = 1'b1;
      end
    end
    dec.over = therm[N_CMP-1];
  end

endmodule : fof_therm_dec

// [hdl/fof_coder.sv]
`timescale 1ns/10ps
module fof_coder
  import fof_pkg::*;
#(
  parameter int unsigned W = WORD_W
) (
  input  wire logic [W-1:0] raw,
  input  wire logic         over,
  input  wire logic         msb_inv,
  input  wire logic         low_inv,
  output logic      [W-1:0] word
);

  // ==========================================================
  // Checks
  if (W < 2) begin : g_bad_width
    $error("word width must be at least two");
  end

  // ==========================================================
  // Coding
  logic [W-1:0] forced;

  always_comb begin
    forced = over ? {W{1'b1}} : raw;
    word   = forced ^ {msb_inv, {(W-1){low_inv}}};
  end

endmodule : fof_coder

// [hdl/fof_top.sv]
// Overview of operation
// - Each conversion result leaves as one 8-bit parallel word.
// - One word is produced per clock, for a nominal rate of 300 MSPS.
// - The two inversion controls select straight, inverted, two's or inverted two's coding.
// - An inversion control that is never set reads as zero, giving straight binary.
// - Thermometer decoding keeps a single sparkle error within two codes, except a sparkle on the top comparator, which alone raises overrange.
// - A valid flag marks when the output word may be taken.
// - The valid flag passes the same pipeline delay as the data word.
// - A polarity control selects the sense of the valid flag.
// - The top control inverts only the top bit, the lower control the seven lower bits.
// - Above full scale the overrange bit goes high; at or above it all eight data bits go high in straight coding.
// - The word appears one clock after the sample is taken.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module fof_top
  import fof_pkg::*;
#(
  parameter int unsigned N_CMP = CMP_N,
  parameter int unsigned W     = WORD_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [N_CMP-1:0]  therm,
  input  wire logic              therm_valid,
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [BUS_DW-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [BUS_DW-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [W-1:0]      sample_word,
  output logic                   overrange_bit,
  output logic                   sample_valid_flag,
  output logic                   irq
);

  // ==========================================================
  // Checks
  if (W != WORD_W) begin : g_bad_word
    $error("word width must match the register layout");
  end
  if (N_CMP != (1 << W)) begin : g_bad_cmp
    $error("comparator count must equal two to the word width");
  end

  // ==========================================================
  // State
  typedef struct packed {
    fof_ctrl_t         ctrl;
    logic [N_CMP-1:0]  therm;
    logic              taken;
    logic [W-1:0]      word;
    logic              over;
    logic              ready;
    logic              flag;
    logic [W-1:0]      last_word;
    logic              last_over;
    logic [BUS_DW-1:0] count;
    logic [IRQ_W-1:0]  int_stat;
    logic [IRQ_W-1:0]  int_mask;
    logic              irq;
    logic              wait_req;
    logic [BUS_DW-1:0] rdata;
  } fof_state_t;

  fof_state_t   s_q;
  fof_state_t   s_d;
  fof_avm_req_t req;
  fof_sample_t  dec;
  logic [W-1:0] coded;
  logic [BUS_DW-1:0] rd_mux;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  clr;
  logic              wr_now;

  // ==========================================================
  // Datapath pieces
  fof_therm_dec #(
    .N_CMP (N_CMP),
    .W     (W)
  ) u_dec (
    .therm (s_q.therm),
    .dec   (dec)
  );

  fof_coder #(
    .W (W)
  ) u_coder (
    .raw     (dec.word),
    .over    (dec.over),
    .msb_inv (s_q.ctrl.msb_invert_ctl),
    .low_inv (s_q.ctrl.lower_bits_invert_ctl),
    .word    (coded)
  );

  // ==========================================================
  // Bus request bundle
  always_comb begin
    req.address    = avs_address;
    req.read       = avs_read;
    req.write      = avs_write;
    req.writedata  = avs_writedata;
    req.byteenable = avs_byteenable;
  end

  // ==========================================================
  // Read mux
  // Unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    case (req.address)
      OFS_CTRL: begin
        rd_mux[CTRL_MSB_INV]   = s_q.ctrl.msb_invert_ctl;
        rd_mux[CTRL_LOW_INV]   = s_q.ctrl.lower_bits_invert_ctl;
        rd_mux[CTRL_VALID_POL] = s_q.ctrl.valid_polarity_ctl;
        rd_mux[CTRL_ENABLE]    = s_q.ctrl.enable;
      end
      OFS_STATUS: begin
        rd_mux[W-1:0]     = s_q.last_word;
        rd_mux[STAT_OVER] = s_q.last_over;
      end
      OFS_INT_STAT: begin
        rd_mux[IRQ_W-1:0] = s_q.int_stat;
      end
      OFS_INT_MASK: begin
        rd_mux[IRQ_W-1:0] = s_q.int_mask;
      end
      OFS_COUNT: begin
        rd_mux = s_q.count;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d    = s_q;
    ev     = '0;
    clr    = '0;
    wr_now = req.write && !s_q.wait_req && req.byteenable[0];

    // Sample capture: comparators latch into this stage
    s_d.taken = therm_valid && s_q.ctrl.enable;
    if (s_d.taken) begin
      s_d.therm = therm;
    end

    // Output stage, one clock behind capture
    s_d.ready = s_q.taken;
    if (s_q.taken) begin
      s_d.word = coded;
      s_d.over = dec.over;
      s_d.count = s_q.count + BUS_DW'(1);
      ev[INT_OVER]   = dec.over;
      ev[INT_BUBBLE] = dec.bubble;
    end
    // Flag tracks the word stage, sense set by software
    s_d.flag = s_d.ready ^ s_q.ctrl.valid_polarity_ctl;

    // Snapshot for software of the word last driven
    if (s_q.ready) begin
      s_d.last_word = s_q.word;
      s_d.last_over = s_q.over;
    end

    // Bus: one wait cycle, then a one-cycle grant
    if ((req.read || req.write) && s_q.wait_req) begin
      s_d.wait_req = 1'b0;
      s_d.rdata    = rd_mux;
    end else begin
      s_d.wait_req = 1'b1;
    end

    if (wr_now) begin
      case (req.address)
        OFS_CTRL: begin
          s_d.ctrl.msb_invert_ctl        = req.writedata[CTRL_MSB_INV];
          s_d.ctrl.lower_bits_invert_ctl = req.writedata[CTRL_LOW_INV];
          s_d.ctrl.valid_polarity_ctl    = req.writedata[CTRL_VALID_POL];
          s_d.ctrl.enable                = req.writedata[CTRL_ENABLE];
        end
        OFS_INT_STAT: begin
          clr = req.writedata[IRQ_W-1:0];
        end
        OFS_INT_MASK: begin
          s_d.int_mask = req.writedata[IRQ_W-1:0];
        end
        OFS_COUNT: begin
          s_d.count = '0;
        end
        default: begin
          clr = '0;
        end
      endcase
    end

    // A new event outruns a clear in the same cycle
    s_d.int_stat = (s_q.int_stat & ~clr) | ev;
    s_d.irq      = |(s_d.int_stat & s_d.int_mask);
  end

  // ==========================================================
  // Registers
  // Inversion controls come up clear so coding starts straight
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q                                <= '0;
      s_q.ctrl.msb_invert_ctl            <= 1'b0;
      s_q.ctrl.lower_bits_invert_ctl     <= 1'b0;
      s_q.ctrl.enable                    <= CTRL_ENABLE_RST;
      s_q.int_mask                       <= INT_MASK_RST;
      s_q.wait_req                       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    avs_readdata      = s_q.rdata;
    avs_waitrequest   = s_q.wait_req;
    sample_word       = s_q.word;
    overrange_bit     = s_q.over;
    sample_valid_flag = s_q.flag;
    irq               = s_q.irq;
  end

endmodule : fof_top

// [dv/fof_monitor.sv]
`timescale 1ns/10ps
module fof_monitor
  import fof_pkg::*;
#(
  parameter int unsigned N_CMP = CMP_N,
  parameter int unsigned W     = WORD_W
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [N_CMP-1:0] therm,
  input wire logic             therm_valid,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest,
  input wire logic [W-1:0]     sample_word,
  input wire logic             overrange_bit,
  input wire logic             sample_valid_flag
);
  // ========================================
  // Sample path
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  word_hold_a: assert property ($changed({sample_word, overrange_bit}) && !$past(rst)
    |-> $past(therm_valid, 2)) else $error("word moved without sample");
  over_rise_a: assert property ($rose(overrange_bit) |-> $past(therm[N_CMP-1], 2))
    else $error("overrange below full scale");
  over_fall_a: assert property ($fell(overrange_bit) && !$past(rst)
    |-> !$past(therm[N_CMP-1], 2)) else $error("overrange lost at full scale");
  over_word_a: assert property (overrange_bit
    |-> sample_word inside {8'hFF, 8'h00, 8'h7F, 8'h80}) else $error("overrange word");
  // Polarity writes excluded: they move the flag on their own
  flag_track_a: assert property ($changed(sample_word) && !$past(therm_valid, 3)
    && !$past(avs_write, 2) && !$past(rst) |-> $changed(sample_valid_flag))
    else $error("flag missed new word");
  // ========================================
  // Register bus
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("grant too long");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("grant without request");
  wait_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not granted");
endmodule : fof_monitor

bind fof_top fof_monitor #(.N_CMP(N_CMP), .W(W)) mon_u (
  .clk(clk), .rst(rst), .therm(therm), .therm_valid(therm_valid),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .sample_word(sample_word), .overrange_bit(overrange_bit),
  .sample_valid_flag(sample_valid_flag)
);

// [dv/fof_capture.sv]
`timescale 1ns/10ps
module fof_capture
  import fof_pkg::*;
(
  input wire logic              clk,
  input wire logic              pol,
  input wire logic [WORD_W-1:0] sample_word,
  input wire logic              overrange_bit,
  input wire logic              sample_valid_flag,
  output logic     [WORD_W:0]   cap_q,
  output int                    cap_n
);
  // ========================================
  // Latch only on the flag, never on the data itself
  always @(posedge clk) begin
    if (sample_valid_flag != pol) begin
      cap_q <= {overrange_bit, sample_word};
      cap_n <= cap_n + 1;
    end
  end
endmodule : fof_capture

// [dv/fof_top_test.sv]
`timescale 1ns/10ps
module fof_top_test
  import fof_pkg::*;
;
  logic              clk, rst, therm_valid, avs_read, avs_write, pol;
  logic              avs_waitrequest, overrange_bit, sample_valid_flag, irq;
  logic [CMP_N-1:0]  therm;
  logic [BUS_AW-1:0] avs_address;
  logic [BUS_DW-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0]        avs_byteenable;
  logic [WORD_W-1:0] sample_word;
  logic [WORD_W:0]   cap_q;
  int                cap_n, base, n_mismatch, comparisons, cyc;
  int                lv[6] = '{0, 1, 127, 128, 255, 256};

  fof_top dut_u (.clk(clk), .rst(rst), .therm(therm), .therm_valid(therm_valid),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_word(sample_word), .overrange_bit(overrange_bit),
    .sample_valid_flag(sample_valid_flag), .irq(irq));
  fof_capture cap_u (.clk(clk), .pol(pol), .sample_word(sample_word),
    .overrange_bit(overrange_bit), .sample_valid_flag(sample_valid_flag),
    .cap_q(cap_q), .cap_n(cap_n));

  // ========================================
  // Helpers
  function automatic logic [CMP_N-1:0] ones(input int n);
    return {CMP_N{1'b1}} >> (CMP_N - n);
  endfunction : ones

  function automatic logic [WORD_W:0] code(input int n, input int m);
    logic [WORD_W-1:0] r;
    r = (n >= CMP_N - 1) ? 8'hFF : WORD_W'(n);
    return {n >= CMP_N, r ^ {m[0], {(WORD_W-1){m[1]}}}};
  endfunction : code

  task automatic chk(input logic [BUS_DW-1:0] got, input logic [BUS_DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // Extra idle edge after release keeps back-to-back calls race free
  task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read  <= 0;
    @(posedge clk);
  endtask : bus

  task automatic smp(input logic [CMP_N-1:0] t, input logic [WORD_W:0] e, input logic act);
    therm       <= t;
    therm_valid <= 1;
    @(posedge clk);
    therm_valid <= 0;
    @(posedge clk);
    @(negedge clk);
    chk({overrange_bit, sample_word}, e);
    chk(sample_valid_flag, act ^ pol);
    @(posedge clk);
  endtask : smp

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ========================================
  // Clock and timeout
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("mismatch %0t timeout", $time);
      finish_test();
    end
  end

  // ========================================
  // Sequence
  initial begin
    {rst, therm_valid, avs_read, avs_write, pol} = 5'h10;
    therm          = '0;
    avs_address    = '0;
    avs_writedata  = '0;
    avs_byteenable = 4'hF;
    repeat (5) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    avs_byteenable <= 4'h0;
    bus(1, OFS_CTRL, 32'h3);
    avs_byteenable <= 4'hF;
    bus(0, OFS_CTRL, 0);
    chk(rd, 32'h8);
    bus(0, OFS_INT_MASK, 0);
    chk(rd, 32'h0);
    bus(0, 5'h14, 0);
    chk(rd, 32'h0);
    for (int m = 0; m < 4; m++) begin
      bus(1, OFS_CTRL, 32'h8 | m);
      foreach (lv[i]) smp(ones(lv[i]), code(lv[i], m), 1);
    end
    bus(1, OFS_CTRL, 32'h8);
    base = cap_n;
    for (int i = 0; i < 6; i++) begin
      therm       <= ones(10 * i + 10);
      therm_valid <= (i < 3);
      @(negedge clk);
      if (i > 1 && i < 5) chk(sample_word, code(10 * i - 10, 0));
      if (i > 0) chk(sample_valid_flag, i > 1 && i < 5);
      @(posedge clk);
    end
    chk(cap_n - base, 3);
    chk(cap_q, code(30, 0));
    bus(1, OFS_CTRL, 32'hC);
    pol <= 1;
    @(negedge clk);
    chk(sample_valid_flag, 1);
    @(posedge clk);
    bus(1, OFS_INT_STAT, 32'h3);
    bus(1, OFS_INT_MASK, 32'h1);
    smp(ones(256), code(256, 0), 1);
    chk(irq, 1);
    bus(0, OFS_STATUS, 0);
    chk(rd, 32'h1FF);
    bus(1, OFS_INT_STAT, 32'h1);
    @(negedge clk);
    chk(irq, 0);
    @(posedge clk);
    bus(1, OFS_INT_MASK, 32'h0);
    smp(ones(100) | (ones(121) ^ ones(120)), code(100, 0), 1);
    chk(irq, 0);
    bus(0, OFS_INT_STAT, 0);
    chk(rd, 32'h2);
    bus(1, OFS_CTRL, 32'h4);
    smp(ones(50), code(100, 0), 0);
    // Mid-run reset must drop the inversions back to straight binary
    bus(1, OFS_CTRL, 32'hB);
    rst <= 1;
    pol <= 0;
    @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, OFS_CTRL, 0);
    chk(rd, 32'h8);
    smp(ones(127), code(127, 0), 1);
    bus(0, OFS_COUNT, 0);
    chk(rd, 32'h1);
    bus(1, OFS_COUNT, 32'h0);
    bus(0, OFS_COUNT, 0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : fof_top_test
